/* src/sfs_consts.vh */
// constants for the supply fault supervisor: offsets, fields, reset values, timing
// assumes a 50 MHz core clock and a plain one-cycle register strobe port
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SFS_ADDR_W 4
`define SFS_REG_SUPPLY_CFG 4'h0
`define SFS_REG_FAULT_STATUS_REGISTER 4'h1
`define SFS_REG_FUNC_ST 4'h2
`define SFS_REG_FAULT_CLR 4'h3

// ----------------------------------------
// supply_cfg fields
// ----------------------------------------
`define SFS_CFG_GATE_DRIVE_VOLTAGE_LSB 0
`define SFS_CFG_FREQ_BIT 2
`define SFS_CFG_LDO_SET_BIT 3
`define SFS_CFG_LDO_SEL_EN_BIT 4
`define SFS_CFG_SS_LSB 5
`define SFS_CFG_OCP_LSB 7
`define SFS_CFG_RESET 16'h0000

// ----------------------------------------
// status fields
// ----------------------------------------
`define SFS_FLT_BUCK_OCP_BIT 0
`define SFS_FLT_BUCK_OV_BIT 1
`define SFS_FLT_LDO_WARN_BIT 2
`define SFS_FLT_LDO_LIM_BIT 3
`define SFS_FLT_DRV_BIT 4
`define SFS_FUNC_LDO_ST_BIT 0
`define SFS_FUNC_SS_DONE_BIT 1
`define SFS_FUNC_BUCK_TGT_LSB 2

// ----------------------------------------
// buck targets in 100 mV units
// ----------------------------------------
`define SFS_GATE_DRIVE_VOLTAGE_7V 2'b11
`define SFS_GATE_DRIVE_VOLTAGE_10V 2'b10
`define SFS_TGT_6V5 7'h41
`define SFS_TGT_7V0 7'h46
`define SFS_TGT_8V0 7'h50

// ----------------------------------------
// timing
// ----------------------------------------
`define SFS_CLK_HZ 50000000
`define SFS_F_LO_HZ 500000
`define SFS_F_HI_HZ 1000000
`define SFS_OCP_TRIP_CNT 5'h10
`define SFS_OCP_CLEAN_CNT 2'h3
`define SFS_TON_DLY_US 100
`define SFS_SS_BASE_US 250

`endif

/* src/sfs_pwm_tick.v */
// divider making one-cycle period-start pulses at the buck switching rate
// assumes the select changes rarely; a change takes effect at once, on the period in progress
`include "sfs_consts.vh"
`default_nettype none
module sfs_pwm_tick #(
    parameter integer CLK_HZ = `SFS_CLK_HZ
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire fast_i,
    output reg tick_o
);
    localparam integer DIV_LO = CLK_HZ / `SFS_F_LO_HZ;
    localparam integer DIV_HI = CLK_HZ / `SFS_F_HI_HZ;
    reg [15:0] cnt_reg;
    wire [15:0] limit = fast_i ? DIV_HI[15:0] - 16'h0001 : DIV_LO[15:0] - 16'h0001;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (cnt_reg >= limit)
        begin
            cnt_reg <= 16'h0000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* src/sfs_sync.v */
// three-stage synchroniser with agreement of the last two stages
// assumes asynchronous pin inputs; output lags the pin by three to four cycles
`include "sfs_consts.vh"
`default_nettype none
module sfs_sync #(
    parameter integer W = 1
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    integer k;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end
        else
        begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (k = 0; k < W; k = k + 1)
            begin
                if (s2_reg[k] == s3_reg[k])
                    q_o[k] <= s3_reg[k];
            end
        end
    end
endmodule
`default_nettype wire

/* src/sfs_supervisor.v */
// supply fault supervisor: buck switch control, buck and ldo protection, fault pin
// assumes comparator levels on pins, register port on the core clock
//
// Local design decisions: the placing of the registers and strobed register access.
`include "sfs_consts.vh"
`default_nettype none
module sfs_supervisor #(
    parameter integer CLK_HZ = `SFS_CLK_HZ,
    parameter integer TON_DLY_CYC = (`SFS_TON_DLY_US * (`SFS_CLK_HZ / 1000000)),
    parameter integer SS_BASE_CYC = (`SFS_SS_BASE_US * (`SFS_CLK_HZ / 1000000)),
    parameter integer DEAD_CYC = 2
) (
    input wire CLOCK_I,
    input wire RST_B_I,
    input wire [3:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [15:0] RDATA_O,
    input wire BUCK_OV_I,
    input wire BUCK_PEAK_I,
    input wire BUCK_UV_OK_I,
    input wire MAIN_LOW_I,
    input wire PWM_DEMAND_I,
    input wire TRIM_DONE_I,
    input wire LDO_RES_5V_I,
    input wire LDO_WARN_I,
    input wire LDO_LIMIT_I,
    input wire DRV_FAULT_I,
    output reg BUCK_HS_O,
    output reg BUCK_LS_O,
    output reg [6:0] BUCK_TARGET_O,
    output reg DUTY_CLAMP_O,
    output reg LDO_EN_O,
    output reg LDO_5V_O,
    output reg [1:0] LDO_OCP_LEVEL_O,
    output reg LDO_ILIMIT_O,
    output reg [15:0] LDO_RAMP_O,
    output reg FAULT_OUT_N_O
);
    // ----------------------------------------
    // synchronised pin inputs
    // ----------------------------------------
    wire [9:0] pins_s;
    wire ov_s = pins_s[0];
    wire peak_s = pins_s[1];
    wire uv_ok_s = pins_s[2];
    wire main_low_s = pins_s[3];
    wire demand_s = pins_s[4];
    wire trim_s = pins_s[5];
    wire res5_s = pins_s[6];
    wire warn_s = pins_s[7];
    wire lim_s = pins_s[8];
    wire drv_s = pins_s[9];

    sfs_sync #(
        .W(10)
    ) u_sync (
        .clk_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .d_i({DRV_FAULT_I, LDO_LIMIT_I, LDO_WARN_I, LDO_RES_5V_I, TRIM_DONE_I,
              PWM_DEMAND_I, MAIN_LOW_I, BUCK_UV_OK_I, BUCK_PEAK_I, BUCK_OV_I}),
        .q_o(pins_s)
    );

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    reg [15:0] cfg_reg;
    wire [1:0] gate_drive_voltage_sel = cfg_reg[`SFS_CFG_GATE_DRIVE_VOLTAGE_LSB +: 2];
    wire freq_fast = cfg_reg[`SFS_CFG_FREQ_BIT];
    wire ldo_set_5v = cfg_reg[`SFS_CFG_LDO_SET_BIT];
    wire ldo_sel_en = cfg_reg[`SFS_CFG_LDO_SEL_EN_BIT];
    wire [1:0] ss_sel = cfg_reg[`SFS_CFG_SS_LSB +: 2];
    wire [1:0] ocp_sel = cfg_reg[`SFS_CFG_OCP_LSB +: 2];

    wire wr_cfg = WR_I && (ADDR_I == `SFS_REG_SUPPLY_CFG);
    wire wr_clr = WR_I && (ADDR_I == `SFS_REG_FAULT_CLR);

    function [6:0] buck_target;
        input [1:0] code;
        begin
            case (code)
                `SFS_GATE_DRIVE_VOLTAGE_7V: buck_target = `SFS_TGT_6V5;
                `SFS_GATE_DRIVE_VOLTAGE_10V: buck_target = `SFS_TGT_7V0;
                default: buck_target = `SFS_TGT_8V0;
            endcase
        end
    endfunction

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            cfg_reg <= `SFS_CFG_RESET;
        else if (wr_cfg)
            cfg_reg <= WDATA_I;
    end

    // ----------------------------------------
    // pwm period timing
    // ----------------------------------------
    wire period_tick;

    // the frequency field is live; it is meant to be set once, a run-time change retimes the period in progress
    sfs_pwm_tick #(
        .CLK_HZ(CLK_HZ)
    ) u_tick (
        .clk_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .fast_i(freq_fast),
        .tick_o(period_tick)
    );

    // ----------------------------------------
    // buck over-current counting
    // ----------------------------------------
    reg [4:0] ocp_cnt_reg;
    reg [1:0] clean_cnt_reg;
    reg peak_seen_reg;
    reg buck_ocp_flag_reg;
    wire ocp_trip = period_tick && peak_seen_reg && (ocp_cnt_reg + 5'h01 >= `SFS_OCP_TRIP_CNT);

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ocp_cnt_reg <= 5'h00;
            clean_cnt_reg <= 2'h0;
            peak_seen_reg <= 1'b0;
        end
        else if (period_tick)
        begin
            peak_seen_reg <= peak_s;
            if (peak_seen_reg)
            begin
                clean_cnt_reg <= 2'h0;
                if (ocp_cnt_reg < `SFS_OCP_TRIP_CNT)
                    ocp_cnt_reg <= ocp_cnt_reg + 5'h01;
            end
            else if (clean_cnt_reg + 2'h1 == `SFS_OCP_CLEAN_CNT)
            begin
                clean_cnt_reg <= 2'h0;
                ocp_cnt_reg <= 5'h00;
            end
            else
                clean_cnt_reg <= clean_cnt_reg + 2'h1;
        end
        else if (peak_s)
            peak_seen_reg <= 1'b1;
    end

    // set beats a clear arriving in the same cycle
    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            buck_ocp_flag_reg <= 1'b0;
        else if (ocp_trip)
            buck_ocp_flag_reg <= 1'b1;
        else if (wr_clr && WDATA_I[`SFS_FLT_BUCK_OCP_BIT])
            buck_ocp_flag_reg <= 1'b0;
    end

    // ----------------------------------------
    // buck switch sequencing
    // ----------------------------------------
    localparam [3:0] ST_OFF = 4'b0001;
    localparam [3:0] ST_HS = 4'b0010;
    localparam [3:0] ST_DEAD = 4'b0100;
    localparam [3:0] ST_LS = 4'b1000;
    reg [3:0] bst_reg;
    reg [3:0] bst_next;
    reg [7:0] dead_reg;
    wire dead_done = dead_reg >= DEAD_CYC[7:0];

    // the buck only listens to its own inputs; driver faults never enter here
    always @*
    begin
        bst_next = bst_reg;
        case (bst_reg)
            ST_OFF:
                if (!ov_s && period_tick)
                    bst_next = ST_HS;
            ST_HS:
                // low supply: demand is ignored, the high side stays on until a peak or over-voltage
                if (peak_s || (!demand_s && !main_low_s))
                    bst_next = ST_DEAD;
            ST_DEAD:
                if (dead_done)
                    bst_next = ST_LS;
            ST_LS:
                if (period_tick)
                    bst_next = ST_HS;
            default:
                bst_next = ST_OFF;
        endcase
        if (ov_s)
            bst_next = ST_OFF;
    end

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            bst_reg <= ST_OFF;
            dead_reg <= 8'h00;
            BUCK_HS_O <= 1'b0;
            BUCK_LS_O <= 1'b0;
            BUCK_TARGET_O <= `SFS_TGT_8V0;
            DUTY_CLAMP_O <= 1'b0;
        end
        else
        begin
            bst_reg <= bst_next;
            dead_reg <= (bst_next == ST_DEAD && bst_reg == ST_DEAD) ? dead_reg + 8'h01 : 8'h00;
            BUCK_HS_O <= (bst_next == ST_HS);
            BUCK_LS_O <= (bst_next == ST_LS);
            BUCK_TARGET_O <= buck_target(gate_drive_voltage_sel);
            DUTY_CLAMP_O <= main_low_s;
        end
    end

    // ----------------------------------------
    // ldo soft start
    // ----------------------------------------
    localparam [2:0] LS_WAIT = 3'b001;
    localparam [2:0] LS_RAMP = 3'b010;
    localparam [2:0] LS_ON = 3'b100;
    reg [2:0] lst_reg;
    reg [23:0] ltmr_reg;
    wire [23:0] ramp_cyc = SS_BASE_CYC[23:0] << ss_sel;

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            lst_reg <= LS_WAIT;
            ltmr_reg <= 24'h00_0000;
            LDO_EN_O <= 1'b0;
            LDO_RAMP_O <= 16'h0000;
        end
        else
        begin
            case (lst_reg)
                LS_WAIT:
                    if (!(uv_ok_s && trim_s))
                        ltmr_reg <= 24'h00_0000;
                    else if (ltmr_reg + 24'h00_0001 >= TON_DLY_CYC[23:0])
                    begin
                        ltmr_reg <= 24'h00_0000;
                        lst_reg <= LS_RAMP;
                        LDO_EN_O <= 1'b1;
                    end
                    else
                        ltmr_reg <= ltmr_reg + 24'h00_0001;
                LS_RAMP:
                    if (ltmr_reg + 24'h00_0001 >= ramp_cyc)
                    begin
                        lst_reg <= LS_ON;
                        LDO_RAMP_O <= 16'hFFFF;
                    end
                    else
                    begin
                        ltmr_reg <= ltmr_reg + 24'h00_0001;
                        LDO_RAMP_O <= ltmr_reg[23:8];
                    end
                LS_ON:
                    lst_reg <= LS_ON;
                default:
                    lst_reg <= LS_WAIT;
            endcase
        end
    end

    // ----------------------------------------
    // ldo current supervision and fault pin
    // ----------------------------------------
    wire ldo_on = (lst_reg == LS_ON);
    wire ldo_warn = ldo_on && warn_s;
    wire ldo_lim = ldo_on && lim_s;

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            LDO_5V_O <= 1'b0;
            LDO_OCP_LEVEL_O <= 2'b00;
            LDO_ILIMIT_O <= 1'b0;
            FAULT_OUT_N_O <= 1'b1;
        end
        else
        begin
            LDO_5V_O <= ldo_sel_en ? ldo_set_5v : res5_s;
            LDO_OCP_LEVEL_O <= ocp_sel;
            LDO_ILIMIT_O <= ldo_lim;
            // warning is a live level, so the pin releases when the current falls back
            FAULT_OUT_N_O <= !(buck_ocp_flag_reg || ocp_trip || ldo_warn || ldo_lim || drv_s || ov_s);
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            RDATA_O <= 16'h0000;
        else if (RD_I)
        begin
            case (ADDR_I)
                `SFS_REG_SUPPLY_CFG: RDATA_O <= cfg_reg;
                `SFS_REG_FAULT_STATUS_REGISTER: RDATA_O <= {11'h000, drv_s, ldo_lim, ldo_warn, ov_s, buck_ocp_flag_reg};
                `SFS_REG_FUNC_ST: RDATA_O <= {7'h00, BUCK_TARGET_O, ldo_on, LDO_5V_O};
                default: RDATA_O <= 16'h0000;
            endcase
        end
        else
            RDATA_O <= 16'h0000;
    end
endmodule
`default_nettype wire

/* bench/sfs_mcu_model.sv */
// microcontroller model on the far side: watches the active-low fault pin
// assumes the pin is a registered level from the supervisor
`default_nettype none
module sfs_mcu_model (
    input wire logic clk_i,
    input wire logic fault_n_i,
    output logic [7:0] fall_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg = 1'b1;
    initial fall_cnt_o = 8'h00;
    // -------------------------------
    // fault pin watch
    // -------------------------------
    // the mcu only reacts to the pin; it never retunes the buck at run time
    always @(posedge clk_i)
    begin
        last_reg <= fault_n_i;
        if (last_reg === 1'b1 && fault_n_i === 1'b0)
            fall_cnt_o <= fall_cnt_o + 8'h01;
    end
endmodule
`default_nettype wire

/* bench/sfs_chk.sv */
// assertions on the supervisor ports
// assumes pin inputs pass a 3 to 4 cycle synchroniser
`default_nettype none
module sfs_chk (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic BUCK_OV_I,
    input wire logic MAIN_LOW_I,
    input wire logic LDO_WARN_I,
    input wire logic DRV_FAULT_I,
    input wire logic BUCK_HS_O,
    input wire logic BUCK_LS_O,
    input wire logic [6:0] BUCK_TARGET_O,
    input wire logic DUTY_CLAMP_O,
    input wire logic [1:0] LDO_OCP_LEVEL_O,
    input wire logic [15:0] LDO_RAMP_O,
    input wire logic FAULT_OUT_N_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    logic [1:0] lvl_reg;
    always @(posedge CLOCK_I)
        lvl_reg <= WDATA_I[8:7];
    // -------------------------------
    // sequences
    // -------------------------------
    // six cycles covers the synchroniser plus the output flop
    sequence s_ov_held;
        BUCK_OV_I [*6];
    endsequence
    sequence s_warn_held;
        (LDO_WARN_I && LDO_RAMP_O == 16'hffff) [*6];
    endsequence
    // -------------------------------
    // properties
    // -------------------------------
    a_ov_both_off: assert property (s_ov_held |-> !BUCK_HS_O && !BUCK_LS_O)
        else $error("buck switch on during over-voltage");
    a_ov_pin_low: assert property (s_ov_held |-> !FAULT_OUT_N_O)
        else $error("fault pin high during over-voltage");
    a_drv_pin_low: assert property (DRV_FAULT_I [*6] |-> !FAULT_OUT_N_O)
        else $error("fault pin high during driver fault");
    a_no_shoot: assert property (!(BUCK_HS_O && BUCK_LS_O))
        else $error("both buck switches on");
    a_tgt_code: assert property (WR_I && ADDR_I == 4'h0 && WDATA_I[1:0] == 2'b11 |-> ##2 BUCK_TARGET_O == 7'h41)
        else $error("buck target wrong for 7 V drive");
    a_ocp_level: assert property (WR_I && ADDR_I == 4'h0 |-> ##2 LDO_OCP_LEVEL_O == $past(lvl_reg))
        else $error("ldo limit level not taken");
    a_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data outside read answer");
    a_warn_pin: assert property (s_warn_held |-> !FAULT_OUT_N_O)
        else $error("fault pin high during ldo warning");
    a_main_clamp: assert property (MAIN_LOW_I [*6] |-> DUTY_CLAMP_O)
        else $error("duty not clamped at low supply");
endmodule
bind sfs_supervisor sfs_chk u_sfs_chk (.CLOCK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .BUCK_OV_I, .MAIN_LOW_I, .LDO_WARN_I, .DRV_FAULT_I, .BUCK_HS_O, .BUCK_LS_O, .BUCK_TARGET_O,
    .DUTY_CLAMP_O, .LDO_OCP_LEVEL_O, .LDO_RAMP_O, .FAULT_OUT_N_O);
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the supply fault supervisor
// assumes short soft start counts set by parameter
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic c, rb = 1'b0, wr = 1'b0, rd = 1'b0, ov = 1'b0, pk = 1'b0, uv = 1'b0, ml = 1'b0;
    logic tr = 1'b0, r5 = 1'b0, wn = 1'b0, lm = 1'b0, df = 1'b0;
    logic [3:0] ad = 4'h0;
    logic [15:0] wd = 16'h0000, rdo, rp, q;
    logic hs, ls, dc, le, l5, il, fn;
    logic [6:0] tg;
    logic [1:0] lv;
    logic [7:0] falls;
    int error_cnt = 0, total_checks = 0, cyc, t0, t2;
    sfs_supervisor #(.TON_DLY_CYC(10), .SS_BASE_CYC(8)) u_sfs_supervisor (.CLOCK_I(c), .RST_B_I(rb),
        .ADDR_I(ad), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdo), .BUCK_OV_I(ov), .BUCK_PEAK_I(pk),
        .BUCK_UV_OK_I(uv), .MAIN_LOW_I(ml), .PWM_DEMAND_I(1'b1), .TRIM_DONE_I(tr), .LDO_RES_5V_I(r5),
        .LDO_WARN_I(wn), .LDO_LIMIT_I(lm), .DRV_FAULT_I(df), .BUCK_HS_O(hs), .BUCK_LS_O(ls),
        .BUCK_TARGET_O(tg), .DUTY_CLAMP_O(dc), .LDO_EN_O(le), .LDO_5V_O(l5), .LDO_OCP_LEVEL_O(lv),
        .LDO_ILIMIT_O(il), .LDO_RAMP_O(rp), .FAULT_OUT_N_O(fn));
    sfs_mcu_model u_sfs_mcu_model (.clk_i(c), .fault_n_i(fn), .fall_cnt_o(falls));
    initial
    begin
        c = 1'b0;
        forever #10 c = ~c;
    end
    // -------------------------------
    // shared tasks
    // -------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task woe(input string n);
        error_cnt++;
        $display("BAD %s expected done seen timeout", n);
        end_of_test;
    endtask
    task tick(input int n);
        repeat (n) @(posedge c);
        #1;
    endtask
    task wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge c);
        wr <= 1'b1;
        ad <= a;
        wd <= d;
        @(posedge c);
        wr <= 1'b0;
    endtask
    task rreg(input logic [3:0] a);
        @(posedge c);
        rd <= 1'b1;
        ad <= a;
        @(posedge c);
        rd <= 1'b0;
        #1;
        q = rdo;
    endtask
    // counts rising edges of the high side drive; cyc holds the span
    task periods(input int n);
        logic p;
        p = 1'b1;
        cyc = 0;
        while (n > 0)
        begin
            @(posedge c);
            #1;
            if (hs === 1'b1 && p !== 1'b1)
                n--;
            p = hs;
            cyc++;
            if (cyc > 4000)
                woe("pwm period");
        end
    endtask
    // -------------------------------
    // scenarios
    // -------------------------------
    task t_regs;
        logic [6:0] e;
        rreg(4'h0);
        chk("cfg reset", 16'h0000, q);
        chk("target reset", 16'h0050, {9'h0, tg});
        rreg(4'h7);
        chk("unmapped read", 16'h0000, q);
        wreg(4'h1, 16'hffff);
        rreg(4'h1);
        chk("status write ignored", 16'h0000, q);
        for (int i = 0; i < 4; i++)
        begin
            e = (i == 3) ? 7'h41 : (i == 2) ? 7'h46 : 7'h50;
            wreg(4'h0, 16'(i * 129));
            tick(2);
            chk("buck target", {9'h0, e}, {9'h0, tg});
            chk("ldo limit level", 16'(i), {14'h0, lv});
            rreg(4'h2);
            chk("status target", {9'h0, e}, {9'h0, q[8:2]});
        end
        r5 <= 1'b1;
        tick(8);
        chk("ldo 5v by resistor", 16'h0001, {15'h0, l5});
        wreg(4'h0, 16'h0010);
        tick(2);
        chk("ldo 3v3 by register", 16'h0000, {15'h0, l5});
        rreg(4'h2);
        chk("ldo level status", 16'h0000, {15'h0, q[0]});
        r5 <= 1'b0;
        wreg(4'h0, 16'h0018);
        tick(2);
        chk("ldo 5v by register", 16'h0001, {15'h0, l5});
        $display("register test done");
    endtask
    task t_soft(input logic [1:0] sel, output int t);
        logic early;
        rb <= 1'b0;
        uv <= 1'b0;
        tr <= 1'b0;
        wn <= 1'b1;
        tick(3);
        rb <= 1'b1;
        wreg(4'h0, {9'h0, sel, 5'h0});
        uv <= 1'b1;
        tick(20);
        chk("ldo off before trim", 16'h0000, {15'h0, le});
        tr <= 1'b1;
        t = 0;
        early = 1'b0;
        while (rp !== 16'hffff)
        begin
            tick(1);
            t++;
            early = early | (fn !== 1'b1);
            if (t > 3000)
                woe("soft start");
        end
        chk("no ldo fault in ramp", 16'h0000, {15'h0, early});
    endtask
    task t_ldo;
        t_soft(2'd0, t0);
        t_soft(2'd2, t2);
        chk("ramp time follows select", 16'h0001, {15'h0, t2 > t0 + 16});
        tick(8);
        chk("warn pulls pin", 16'h0000, {15'h0, fn});
        wn <= 1'b0;
        tick(8);
        chk("warn releases pin", 16'h0001, {15'h0, fn});
        lm <= 1'b1;
        tick(8);
        chk("ldo current limit", 16'h0001, {15'h0, il});
        lm <= 1'b0;
        tick(8);
        rreg(4'h2);
        chk("soft start done", 16'h0001, {15'h0, q[1]});
        $display("ldo test done");
    endtask
    task t_ocp;
        pk <= 1'b1;
        periods(14);
        rreg(4'h1);
        chk("no early ocp fault", 16'h0000, {15'h0, q[0]});
        periods(4);
        rreg(4'h1);
        chk("ocp flag set", 16'h0001, {15'h0, q[0]});
        chk("ocp pin low", 16'h0000, {15'h0, fn});
        periods(2);
        pk <= 1'b0;
        // one more hit period drains out of the latch, then three clean ones reset the count
        tick(400);
        rreg(4'h1);
        chk("ocp flag sticks", 16'h0001, {15'h0, q[0]});
        wreg(4'h3, 16'h0001);
        tick(3);
        rreg(4'h1);
        chk("ocp flag cleared", 16'h0000, {15'h0, q[0]});
        chk("pin released", 16'h0001, {15'h0, fn});
        pk <= 1'b1;
        periods(10);
        pk <= 1'b0;
        tick(400);
        pk <= 1'b1;
        periods(10);
        pk <= 1'b0;
        rreg(4'h1);
        chk("clean periods reset count", 16'h0000, {15'h0, q[0]});
        $display("buck ocp test done");
    endtask
    task t_freq;
        pk <= 1'b1;
        wreg(4'h0, 16'h0004);
        periods(2);
        periods(4);
        t0 = cyc;
        wreg(4'h0, 16'h0000);
        periods(2);
        periods(4);
        chk("period doubles at 500k", 16'(2 * t0), 16'(cyc));
        pk <= 1'b0;
        tick(300);
        wreg(4'h3, 16'h0001);
        $display("frequency test done");
    endtask
    task t_faults;
        ov <= 1'b1;
        tick(8);
        chk("hs off at ov", 16'h0000, {15'h0, hs});
        chk("ls off at ov", 16'h0000, {15'h0, ls});
        chk("mcu saw fault", 16'h0001, {15'h0, falls != 8'h00});
        ov <= 1'b0;
        df <= 1'b1;
        pk <= 1'b1;
        periods(3);
        chk("driver fault pin", 16'h0000, {15'h0, fn});
        df <= 1'b0;
        pk <= 1'b0;
        ml <= 1'b1;
        tick(8);
        chk("duty clamp", 16'h0001, {15'h0, dc});
        ml <= 1'b0;
        $display("fault test done");
    endtask
    initial
    begin
        repeat (3) @(posedge c);
        rb <= 1'b1;
        t_regs;
        t_ldo;
        t_ocp;
        t_freq;
        t_faults;
        end_of_test;
    end
endmodule
`default_nettype wire
